// ### hw/isa_i2c_slave_ack.sv
// i2c receive slave with acknowledge-time flag, clock stretching and software nack
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module isa_i2c_slave_ack
    import isa_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // bus lines, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // configuration
    input wire logic [ADDR_W-1:0] own_address_i,
    input wire logic ten_bit_mode_i,
    input wire logic address_hold_enable_i,
    input wire logic data_hold_enable_i,
    input wire logic ack_data_value_i,
    // software strobes
    input wire logic clock_release_i,
    input wire logic buffer_read_i,
    // status
    output logic ack_time_flag_o,
    output logic receive_buffer_full_o,
    output logic [7:0] rx_data_o,
    output logic slave_event_o,
    output logic addressed_o
);

    // ------------------------------------------------------------------
    // address acceptance for the byte just shifted in
    // ------------------------------------------------------------------
    function automatic logic byte_accept(input isa_state_e st, input logic [7:0] b,
                                         input logic [ADDR_W-1:0] own, input logic ten);
        logic ok;
        ok = 1'b0;
        unique case (st)
            ISA_ADDR:
            begin
                if (ten)
                    ok = (b[7:3] == ISA_TEN_BIT_PREFIX) && (b[2:1] == own[9:8])
                         && (b[ISA_RW_POS] == ISA_RW_WRITE);
                else
                    ok = (b[7:1] == own[6:0]) && (b[ISA_RW_POS] == ISA_RW_WRITE);
            end
            ISA_ADDR_LO: ok = (b == own[7:0]);
            ISA_DATA: ok = 1'b1;  // payload is never compared to an address
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : byte_accept

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    isa_line_s sync1, sync2, prev;
    isa_line_s next_sync1, next_sync2, next_prev;
    isa_state_e state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] rx_data, next_rx_data;
    logic ack_time, next_ack_time;
    logic receive_buffer_full, next_rbf;
    logic holding, next_holding;
    logic ack_given, next_ack_given;
    logic nack_sticky, next_nack_sticky;
    logic scl_oe, next_scl_oe;
    logic sda_oe, next_sda_oe;
    logic slave_event, next_slave_event;
    logic addressed, next_addressed;

    // line events, from the second synchroniser stage against its one-cycle-delayed copy prev
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic is_addr, hold_en, ok;

    assign scl_rise = ~prev.scl & sync2.scl;
    assign scl_fall = prev.scl & ~sync2.scl;
    assign start_seen = prev.scl & sync2.scl & prev.sda & ~sync2.sda;
    assign stop_seen = prev.scl & sync2.scl & ~prev.sda & sync2.sda;
    assign is_addr = (state == ISA_ADDR) || (state == ISA_ADDR_LO);
    assign hold_en = is_addr ? address_hold_enable_i : data_hold_enable_i;
    assign ok = byte_accept(state, shift, own_address_i, ten_bit_mode_i);

    // ------------------------------------------------------------------
    // next-state computation
    // ------------------------------------------------------------------
    always_comb
    begin
        next_sync1 = '{scl: scl_i, sda: sda_i};
        next_sync2 = sync1;
        next_prev = sync2;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_rx_data = rx_data;
        next_ack_time = ack_time;
        next_rbf = receive_buffer_full & ~buffer_read_i;  // a byte landing below wins over the read
        next_holding = holding;
        next_ack_given = ack_given;
        next_nack_sticky = nack_sticky;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_slave_event = 1'b0;
        next_addressed = addressed;
        if (start_seen)
        begin
            // start or repeated start: back to the address phase
            next_state = ISA_ADDR;
            next_bit_cnt = ISA_CNT_RST;
            next_ack_time = 1'b0;
            next_holding = 1'b0;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
        end
        else if (stop_seen)
        begin
            next_state = ISA_IDLE;
            next_bit_cnt = ISA_CNT_RST;
            next_ack_time = 1'b0;
            next_holding = 1'b0;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
            next_nack_sticky = 1'b0;
        end
        else if ((state != ISA_IDLE) && (state != ISA_IGNORE))
        begin
            if (scl_rise && (bit_cnt < ISA_BITS_PER_BYTE))
            begin
                next_shift = {shift[6:0], sync2.sda};
                next_bit_cnt = bit_cnt + 4'h1;
            end
            else if (scl_rise && (bit_cnt == ISA_BITS_PER_BYTE))
            begin
                next_ack_time = 1'b0;
                next_bit_cnt = ISA_ACK_CLOCK;
            end
            else if (scl_fall && (bit_cnt == ISA_BITS_PER_BYTE))
            begin
                // eighth falling edge: byte complete
                next_ack_given = 1'b0;
                if (ok)
                begin
                    next_ack_time = 1'b1;
                    next_rx_data = shift;
                    next_rbf = 1'b1;
                    next_slave_event = 1'b1;
                    if (hold_en)
                    begin
                        // stretch regardless of the ack data value
                        next_scl_oe = 1'b1;
                        next_holding = 1'b1;
                    end
                    else
                    begin
                        // no stretch: answer at once, byte acked unless nack_sticky is set
                        next_ack_given = ~nack_sticky;
                        next_sda_oe = ~nack_sticky;
                    end
                end
            end
            else if (scl_fall && (bit_cnt == ISA_ACK_CLOCK))
            begin
                // ninth falling edge: drop the acknowledge and move on
                next_sda_oe = 1'b0;
                next_bit_cnt = ISA_CNT_RST;
                if (!ack_given && is_addr)
                    next_state = ISA_IGNORE;
                else if (ack_given && (state == ISA_ADDR) && ten_bit_mode_i)
                    next_state = ISA_ADDR_LO;
                else if (ack_given && is_addr)
                begin
                    next_state = ISA_DATA;
                    next_addressed = 1'b1;
                end
            end
            // software picks ack or nack first; scl is let go one cycle later so
            // the answer on sda is already set up when the master raises the clock
            if (holding && clock_release_i)
            begin
                next_holding = 1'b0;
                next_ack_given = ~(ack_data_value_i | nack_sticky);
                next_sda_oe = ~(ack_data_value_i | nack_sticky);
                if (ack_data_value_i)
                    next_nack_sticky = 1'b1;
            end
            else if (scl_oe && !holding)
            begin
                next_scl_oe = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            sync1 <= '{scl: ISA_LINE_IDLE, sda: ISA_LINE_IDLE};
            sync2 <= '{scl: ISA_LINE_IDLE, sda: ISA_LINE_IDLE};
            prev <= '{scl: ISA_LINE_IDLE, sda: ISA_LINE_IDLE};
            state <= ISA_IDLE;
            bit_cnt <= ISA_CNT_RST;
            shift <= ISA_DATA_RST;
            rx_data <= ISA_DATA_RST;
            ack_time <= 1'b0;
            receive_buffer_full <= 1'b0;
            holding <= 1'b0;
            ack_given <= 1'b0;
            nack_sticky <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            slave_event <= 1'b0;
            addressed <= 1'b0;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            rx_data <= next_rx_data;
            ack_time <= next_ack_time;
            receive_buffer_full <= next_rbf;
            holding <= next_holding;
            ack_given <= next_ack_given;
            nack_sticky <= next_nack_sticky;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            slave_event <= next_slave_event;
            addressed <= next_addressed;
        end
    end

    // ------------------------------------------------------------------
    // outputs from flip-flops, scl_o and sda_o tied to 0; open-drain lines only ever pull low
    // ------------------------------------------------------------------
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe;
    assign sda_oe_o = sda_oe;
    assign ack_time_flag_o = ack_time;
    assign receive_buffer_full_o = receive_buffer_full;
    assign rx_data_o = rx_data;
    assign slave_event_o = slave_event;
    assign addressed_o = addressed;

endmodule : isa_i2c_slave_ack
`default_nettype wire

// ### hw/isa_pkg.sv
// shared constants, states and carriers for the i2c slave acknowledge block
`default_nettype none
package isa_pkg;

    // ------------------------------------------------------------------
    // byte framing counts
    // ------------------------------------------------------------------
    localparam logic [3:0] ISA_BITS_PER_BYTE = 4'h8;  // data bits before the ack clock
    localparam logic [3:0] ISA_ACK_CLOCK = 4'h9;      // count value after the ninth rising edge
    localparam logic [3:0] ISA_CNT_RST = 4'h0;

    // ------------------------------------------------------------------
    // address byte layout
    // ------------------------------------------------------------------
    localparam logic [4:0] ISA_TEN_BIT_PREFIX = 5'h1e;  // upper address byte header 11110
    localparam logic ISA_RW_WRITE = 1'h0;               // direction bit of a master write
    localparam int ISA_RW_POS = 0;                      // direction bit position in address byte

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] ISA_DATA_RST = 8'h00;
    localparam logic ISA_LINE_IDLE = 1'h1;  // released bus lines read high

    // ------------------------------------------------------------------
    // protocol states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ISA_IDLE,
        ISA_ADDR,
        ISA_ADDR_LO,
        ISA_DATA,
        ISA_IGNORE
    } isa_state_e;

    // one sample of the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } isa_line_s;

endpackage : isa_pkg
`default_nettype wire

// ### testbench/isa_sva.sv
// assertion checker for the i2c slave acknowledge block
`timescale 1ns/1ps
`default_nettype none
module isa_sva (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // line and controls
    input wire logic scl_i,
    input wire logic address_hold_enable_i,
    input wire logic data_hold_enable_i,
    input wire logic clock_release_i,
    // watched outputs
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic ack_time_flag_o,
    input wire logic receive_buffer_full_o,
    input wire logic slave_event_o,
    input wire logic addressed_o
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence s_release;
        scl_oe_o && clock_release_i;
    endsequence
    // answer placed first, clock let go one cycle after the release is taken
    sequence s_let_go;
        scl_oe_o ##1 !scl_oe_o;
    endsequence
    // a stretch that no release pulse has touched in this or the last cycle
    sequence s_holding;
        scl_oe_o && !clock_release_i && !$past(clock_release_i);
    endsequence
    sequence s_event;
        slave_event_o ##1 !slave_event_o;
    endsequence
    AST_FLAG_RISE: assert property ($rose(ack_time_flag_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("ack flag rose while clock high");
    AST_FLAG_FALL: assert property ($fell(ack_time_flag_o) |-> $past(scl_i, 2))
        else $error("ack flag fell while clock low");
    AST_STRETCH_FLAG: assert property (scl_oe_o |-> ack_time_flag_o)
        else $error("stretch without ack flag");
    AST_HOLD_ENABLED: assert property ($rose(scl_oe_o) |->
        (addressed_o ? data_hold_enable_i : address_hold_enable_i))
        else $error("stretch with the matching hold off");
    AST_RELEASE: assert property (s_release |=> s_let_go)
        else $error("clock not released");
    AST_HOLD_KEEP: assert property (s_holding |=> scl_oe_o)
        else $error("stretch ended early");
    AST_EVENT: assert property (slave_event_o |-> receive_buffer_full_o && ack_time_flag_o ##0 s_event)
        else $error("byte event without buffer flag");
    AST_ACK_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("data driven while clock high");
endmodule : isa_sva
bind isa_i2c_slave_ack isa_sva u_sva (.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl_i),
    .address_hold_enable_i(address_hold_enable_i), .data_hold_enable_i(data_hold_enable_i),
    .clock_release_i(clock_release_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
    .ack_time_flag_o(ack_time_flag_o), .receive_buffer_full_o(receive_buffer_full_o),
    .slave_event_o(slave_event_o), .addressed_o(addressed_o));
`default_nettype wire

// ### testbench/isa_master.sv
// behavioural i2c bus master on the far side of the slave
`timescale 1ns/1ps
`default_nettype none
module isa_master (
    // resolved line levels
    input wire logic scl_l,
    input wire logic sda_l,
    // line releases, low pulls the line
    output logic scl_m,
    output logic sda_m
);
    // quarter and half of the 64 ns link clock
    localparam int Q = 16;
    localparam int H = 32;
    initial scl_m = 1'b1;
    initial sda_m = 1'b1;
    // one clock pulse, waiting out any stretch
    task automatic pulse(output logic b);
        #Q scl_m = 1'b1;
        while (scl_l !== 1'b1) #4;
        b = sda_l;
        #H scl_m = 1'b0;
        #Q;
    endtask : pulse
    // start and stop conditions
    task automatic start_c;
        sda_m = 1'b1;
        #Q scl_m = 1'b1;
        #H sda_m = 1'b0;
        #H scl_m = 1'b0;
        #Q;
    endtask : start_c
    task automatic stop_c;
        sda_m = 1'b0;
        #Q scl_m = 1'b1;
        #H sda_m = 1'b1;
        #H;
    endtask : stop_c
    // eight bits msb first, then the acknowledge clock
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            sda_m = d[i];
            pulse(b);
        end
        sda_m = 1'b1;
        #H pulse(ack);
    endtask : put_byte
endmodule : isa_master
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the i2c slave acknowledge block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import isa_pkg::*;
;
    logic clock_i = 1'b0, resetn_i = 1'b0, ten_bit_mode_i = 1'b0, sw_nack = 1'b0;
    logic address_hold_enable_i = 1'b0, data_hold_enable_i = 1'b0, ack_data_value_i = 1'b1;
    logic clock_release_i = 1'b0, buffer_read_i = 1'b0, a;
    logic [9:0] own_address_i = 10'h000;
    logic [15:0] lfsr = 16'h0001;
    logic [7:0] a0, d, rx_data_o;
    logic scl_m, sda_m, scl_o, scl_oe_o, sda_o, sda_oe_o, ack_time_flag_o;
    logic receive_buffer_full_o, slave_event_o, addressed_o;
    wire logic scl_l, sda_l;
    int num_errors = 0, n_compared = 0, hold_cnt = 0, n_holds = 0, h0;
    int exp_h[5] = '{3, 0, 3, 0, 3};
    int n_events = 0, e0;
    // ----
    // bus, clock and parts
    // ----
    assign scl_l = scl_m & (scl_oe_o ? scl_o : 1'b1);
    assign sda_l = sda_m & (sda_oe_o ? sda_o : 1'b1);
    always #2.5 clock_i = ~clock_i;
    isa_master m (.scl_l(scl_l), .sda_l(sda_l), .scl_m(scl_m), .sda_m(sda_m));
    isa_i2c_slave_ack dut (.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl_l),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_l), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .own_address_i(own_address_i), .ten_bit_mode_i(ten_bit_mode_i),
        .address_hold_enable_i(address_hold_enable_i), .data_hold_enable_i(data_hold_enable_i),
        .ack_data_value_i(ack_data_value_i), .clock_release_i(clock_release_i),
        .buffer_read_i(buffer_read_i), .ack_time_flag_o(ack_time_flag_o),
        .receive_buffer_full_o(receive_buffer_full_o), .rx_data_o(rx_data_o),
        .slave_event_o(slave_event_o), .addressed_o(addressed_o));
    // software side: release each stretch late, ack value kept high otherwise
    always @(posedge clock_i)
    begin
        hold_cnt <= (scl_oe_o === 1'b1) ? hold_cnt + 1 : 0;
        clock_release_i <= (hold_cnt == 20);
        ack_data_value_i <= (hold_cnt == 20) ? sw_nack : 1'b1;
        if (slave_event_o === 1'b1)
            n_events <= n_events + 1;
        if (hold_cnt == 20)
        begin
            n_holds <= n_holds + 1;
            chk_bit(ack_time_flag_o, 1'b1);
        end
    end
    // ----
    // compare, model and end of run
    // ----
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit
    // one byte: ack bit, landed data and flags against the model
    task automatic xfer(input logic [7:0] b, input logic ok, input logic land);
        m.put_byte(b, a);
        chk_bit(a, !ok);
        chk_bit(ack_time_flag_o, 1'b0);
        if (land)
        begin
            chk_byte(rx_data_o, b);
            chk_bit(receive_buffer_full_o, 1'b1);
        end
        @(posedge clock_i) buffer_read_i <= 1'b1;
        @(posedge clock_i) buffer_read_i <= 1'b0;
    endtask : xfer
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    // watchdog
    initial
    begin
        #200000;
        num_errors++;
        summarize();
    end
    // scenarios: hold, no hold, software nack, foreign address, ten-bit
    initial
    begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        for (int sc = 0; sc < 5; sc++)
        begin
            @(posedge clock_i);
            lfsr = lfsr_next(lfsr);
            own_address_i <= lfsr[9:0];
            ten_bit_mode_i <= (sc == 4);
            address_hold_enable_i <= (sc != 1);
            data_hold_enable_i <= (sc != 1);
            @(posedge clock_i) sw_nack <= 1'b0;
            @(posedge clock_i) h0 = n_holds;
            e0 = n_events;
            a0 = {own_address_i[6:0], ISA_RW_WRITE};
            d = lfsr[15:8];
            m.start_c();
            case (sc)
                3:
                begin
                    xfer(a0 ^ 8'h02, 1'b0, 1'b0);
                    xfer(a0, 1'b0, 1'b0);
                    chk_bit(addressed_o, 1'b0);
                    chk_bit(receive_buffer_full_o, 1'b0);
                end
                4:
                begin
                    xfer({ISA_TEN_BIT_PREFIX, own_address_i[9:8], ISA_RW_WRITE},
                         1'b1, 1'b1);
                    xfer(own_address_i[7:0], 1'b1, 1'b1);
                    xfer(d, 1'b1, 1'b1);
                end
                default:
                begin
                    xfer(a0, 1'b1, 1'b1);
                    chk_bit(addressed_o, 1'b1);
                    sw_nack <= (sc == 2);
                    xfer(d, sc != 2, 1'b1);
                    xfer(~d, sc != 2, 1'b1);
                end
            endcase
            m.stop_c();
            chk_byte(8'(n_holds - h0), 8'(exp_h[sc]));
            chk_byte(8'(n_events - e0), (sc == 3) ? 8'h00 : 8'h03);
            sw_nack <= 1'b0;
            m.start_c();
            xfer(a0 ^ {7'h00, ten_bit_mode_i}, sc != 4, sc != 4);
            m.stop_c();
        end
        summarize();
    end
endmodule : testbench
`default_nettype wire
